// ---- debug_trigger_pkg.sv ----
package debug_trigger_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFF_TRIG_CFG = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_CONTROL  = 8'h08;
  localparam logic [7:0] OFF_CMP_A    = 8'h0C;
  localparam logic [7:0] OFF_CMP_B    = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // trigger_config_reg fields
  localparam int TC_QUALIFY_BIT = 7;
  localparam int TC_BEGIN_BIT   = 6;
  localparam logic [7:0] TC_WRITE_MASK = 8'hCF;

  // debug_control_reg fields
  localparam int DC_ENABLE_BIT = 7;
  localparam int DC_ARM_BIT    = 6;
  localparam int DC_BRKEN_BIT  = 4;

  // Interrupt status fields
  localparam int IRQ_W        = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TRIG_BIT = 1;

  // Reset values
  localparam logic [7:0]  RST_TRIG_CFG = 8'h00;
  localparam logic [7:0]  RST_CONTROL  = 8'h00;
  localparam logic [15:0] RST_CMP      = 16'h0000;
  localparam logic [3:0]  RST_COUNT    = 4'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

  // FIFO depth as a count value
  localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;
  localparam logic [3:0] FIFO_LAST_SLOT  = 4'h7;

  // trigger_mode_code values
  localparam logic [3:0] MODE_A_ONLY      = 4'h0;
  localparam logic [3:0] MODE_A_OR_B      = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B    = 4'h2;
  localparam logic [3:0] MODE_EV_B        = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EV_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_BDAT  = 4'h5;
  localparam logic [3:0] MODE_A_NOT_BDAT  = 4'h6;
  localparam logic [3:0] MODE_INSIDE      = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE     = 4'h8;

  // CPU bus observation carrier
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        access;
    logic        exec;
    logic        cof;
  } cpu_watch_t;

  // Trace store carrier
  typedef struct packed {
    logic        store;
    logic [15:0] word;
  } trace_out_t;

endpackage : debug_trigger_pkg

// ---- debug_trigger_and_trace_status.sv ----
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
// Operation
// RULE1: Trigger config readable always; writes ignored while armed.
// RULE2: Trigger config bits 4 and 5 always read zero, writes dropped.
// RULE3: Qualify bit 7 set: only executed opcodes match; clear: any access.
// RULE4: Begin bit 6: 0 circular fill ended by trigger, 1 trigger starts fill.
// RULE5: Event-only modes ignore begin bit and always run as begin trace.
// RULE6: Mode codes 0 to 6 decode A, A|B, A then B, event modes, data modes.
// RULE7: Code 7 inside range, 8 outside range, 9 to 15 never trigger.
// RULE8: Status bit 7 A flag clears at run start, sets on A match armed.
// RULE9: Status bit 6 B flag clears at run start, sets on B match armed.
// RULE10: Status bit 5 shows arm bit while enabled; clears when run ends.
// RULE11: Run ends on FIFO full in begin trace, on trigger in end trace.
// RULE12: Writing 0 to arm or enable ends the run and clears armed flag.
// RULE13: Status bits 3:0 count valid words, cleared at start, up to 8.
// RULE14: Valid count never decrements on readout; host tracks remainder.
// RULE15: Trace status register is read-only; writes change nothing.
// RULE16: Arm is control bit 6; write sets it, run completion clears it.
// RULE17: Break on trigger in end trace, on FIFO full in begin trace.
// RULE18: Registers are eight bits and reset to zero, module disarmed; here comparators A and B are 16 bits.
module debug_trigger_and_trace_status
  import debug_trigger_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // CPU bus observation
  input  wire cpu_watch_t  cpu,
  // Trace, break and interrupt outputs
  output trace_out_t       trace,
  output logic             break_req,
  output logic             irq
);

  typedef struct packed {
    logic [7:0]       tcfg;
    logic [7:0]       ctrl;
    logic [15:0]      cmp_a;
    logic [15:0]      cmp_b;
    logic [3:0]       cnt;
    logic             af;
    logic             bf;
    logic             trig_seen;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
    logic             irq;
    logic             brk;
    trace_out_t       trace;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } state_t;

  state_t r;
  state_t s;

  logic             strobe;
  logic             ma;
  logic             mb;
  logic             bdat;
  logic             in_range;
  logic             trig;
  logic             ev_mode;
  logic             begin_trace;
  logic             capturing;
  logic             do_store;
  logic [15:0]      store_word;
  logic             run_end;
  logic             armed;
  logic             wr;
  logic             rd_phase;
  logic             mapped;
  logic [7:0]       status_byte;
  logic [7:0]       rd_byte;
  logic [15:0]      rd_half;
  logic [IRQ_W-1:0] ist_set;
  logic [IRQ_W-1:0] ist_clr;

  always_comb begin
    s           = r;
    s.brk       = 1'b0;
    s.trace     = '0;
    run_end     = 1'b0;
    ist_set     = '0;
    ist_clr     = '0;
    armed       = r.ctrl[DC_ARM_BIT] & r.ctrl[DC_ENABLE_BIT];

    // Match strobe: executed opcode or any access
    strobe = r.tcfg[TC_QUALIFY_BIT] ? cpu.exec : cpu.access; // RULE3
    ma       = strobe && (cpu.addr == r.cmp_a);
    mb       = strobe && (cpu.addr == r.cmp_b);
    bdat     = strobe && (cpu.data == r.cmp_b[7:0]);
    in_range = strobe && (cpu.addr >= r.cmp_a) && (cpu.addr <= r.cmp_b);

    ev_mode = (r.tcfg[3:0] == MODE_EV_B) ||
              (r.tcfg[3:0] == MODE_A_THEN_EV_B);
    begin_trace = ev_mode | r.tcfg[TC_BEGIN_BIT]; // RULE5

    case (r.tcfg[3:0]) // RULE6
      MODE_A_ONLY:      trig = ma;
      MODE_A_OR_B:      trig = ma | mb;
      MODE_A_THEN_B:    trig = mb & r.af;
      MODE_EV_B:        trig = mb;
      MODE_A_THEN_EV_B: trig = mb & r.af;
      MODE_A_AND_BDAT:  trig = ma & bdat;
      MODE_A_NOT_BDAT:  trig = ma & ~bdat;
      MODE_INSIDE:      trig = in_range; // RULE7
      MODE_OUTSIDE:     trig = strobe & ~in_range; // RULE7
      default:          trig = 1'b0; // RULE7
    endcase

    // Event modes store bus data on each qualified B; others store flow
    capturing = ~begin_trace | r.trig_seen; // RULE4
    if (ev_mode) begin
      do_store   = trig;
      store_word = {8'h00, cpu.data};
    end else begin
      do_store   = cpu.cof & capturing;
      store_word = cpu.addr;
    end

    if (armed) begin
      if (ma) begin
        s.af = 1'b1; // RULE8
      end
      if (mb) begin
        s.bf = 1'b1; // RULE9
      end
      if (trig && !r.trig_seen) begin
        s.trig_seen           = 1'b1;
        ist_set[IRQ_TRIG_BIT] = 1'b1;
        if (!begin_trace) begin
          run_end = 1'b1; // RULE11
          s.brk   = r.ctrl[DC_BRKEN_BIT]; // RULE17
        end
      end
      if (do_store) begin
        s.trace.store = 1'b1;
        s.trace.word  = store_word;
        if (r.cnt < FIFO_FULL_COUNT) begin
          s.cnt = r.cnt + 4'h1; // RULE13
        end
        if (begin_trace && r.cnt == FIFO_LAST_SLOT) begin
          run_end = 1'b1; // RULE11
          s.brk   = r.ctrl[DC_BRKEN_BIT]; // RULE17
        end
      end
    end

    if (run_end) begin
      s.ctrl[DC_ARM_BIT]    = 1'b0; // RULE16
      ist_set[IRQ_DONE_BIT] = 1'b1;
    end

    // APB: answer one cycle into the access phase
    rd_phase  = psel & penable & ~r.pready;
    wr        = psel & penable & r.pready & pwrite;
    s.pready  = rd_phase;
    mapped    = (paddr == OFF_TRIG_CFG) || (paddr == OFF_STATUS) ||
                (paddr == OFF_CONTROL)  || (paddr == OFF_CMP_A)  ||
                (paddr == OFF_CMP_B)    || (paddr == OFF_IRQ_STAT) ||
                (paddr == OFF_IRQ_MASK);
    s.pslverr = rd_phase & ~mapped;

    status_byte = {r.af, r.bf, armed, 1'b0, r.cnt}; // RULE10 RULE14
    rd_byte = 8'h00;
    rd_half = 16'h0000;
    case (paddr)
      OFF_TRIG_CFG: rd_byte = r.tcfg & TC_WRITE_MASK; // RULE1 RULE2
      OFF_STATUS:   rd_byte = status_byte;
      OFF_CONTROL:  rd_byte = r.ctrl;
      OFF_CMP_A:    rd_half = r.cmp_a;
      OFF_CMP_B:    rd_half = r.cmp_b;
      OFF_IRQ_STAT: rd_byte = {6'h00, r.ist};
      OFF_IRQ_MASK: rd_byte = {6'h00, r.imask};
      default:      rd_byte = 8'h00;
    endcase
    if (rd_phase) begin
      s.prdata = {16'h0000, rd_half | {8'h00, rd_byte}};
    end else begin
      s.prdata = 32'h0000_0000;
    end

    if (wr) begin
      case (paddr)
        OFF_TRIG_CFG: begin
          if (!armed) begin
            s.tcfg = pwdata[7:0] & TC_WRITE_MASK; // RULE1 RULE2
          end
        end
        OFF_CONTROL: begin
          s.ctrl = pwdata[7:0];
          if (!pwdata[DC_ENABLE_BIT] || !pwdata[DC_ARM_BIT]) begin
            s.ctrl[DC_ARM_BIT] = 1'b0; // RULE12
          end else if (!armed) begin
            // Start of a debug run
            s.af        = 1'b0; // RULE8
            s.bf        = 1'b0; // RULE9
            s.cnt       = RST_COUNT; // RULE13
            s.trig_seen = 1'b0;
          end else begin
            s.ctrl[DC_ARM_BIT] = ~run_end;
          end
        end
        OFF_CMP_A:    s.cmp_a = pwdata[15:0];
        OFF_CMP_B:    s.cmp_b = pwdata[15:0];
        OFF_IRQ_STAT: ist_clr = pwdata[IRQ_W-1:0];
        OFF_IRQ_MASK: s.imask = pwdata[IRQ_W-1:0];
        default:      s.imask = r.imask; // RULE15
      endcase
    end

    // Hardware set wins over a one-written clear
    s.ist = (r.ist & ~ist_clr) | ist_set;
    s.irq = |(s.ist & s.imask);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      r        <= '0; // RULE18
      r.tcfg   <= RST_TRIG_CFG;
      r.ctrl   <= RST_CONTROL;
      r.cmp_a  <= RST_CMP;
      r.cmp_b  <= RST_CMP;
      r.cnt    <= RST_COUNT;
      r.ist    <= RST_IRQ;
      r.imask  <= RST_IRQ;
    end else begin
      r <= s;
    end
  end

  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign trace     = r.trace;
  assign break_req = r.brk;
  assign irq       = r.irq;

endmodule : debug_trigger_and_trace_status

// ---- debug_trigger_properties.sv ----
`timescale 1ns/100ps
module debug_trigger_properties
  import debug_trigger_pkg::*;
(
  // Register bus
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Break and interrupt
  input wire logic        break_req,
  input wire logic        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_answer_time: assert property (psel && penable && !pready |=> pready)
    else $error("late answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_idle_quiet: assert property (!pready |-> !prdata && !pslverr)
    else $error("idle data");
  a_bad_addr: assert property (pready && paddr > OFF_IRQ_MASK |-> pslverr)
    else $error("no slave error");
  a_cfg_zero: assert property (
    pready && paddr == OFF_TRIG_CFG |-> prdata[5:4] == 2'b00)
    else $error("config bits set");
  a_status_fmt: assert property (
    pready && paddr == OFF_STATUS |-> !prdata[4] && prdata[3:0] <= 4'h8)
    else $error("bad status");
  a_break_pulse: assert property (break_req |=> !break_req)
    else $error("break held");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=>
    !pready && !irq && !break_req) else $error("busy in reset");
  cover property (break_req);
  cover property (pslverr);
  cover property (irq);
endmodule : debug_trigger_properties
bind debug_trigger_and_trace_status debug_trigger_properties props (.mclk,
  .rst_b, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .break_req,
  .irq);

// ---- cpu_bus_model.sv ----
`timescale 1ns/100ps
module cpu_bus_model
  import debug_trigger_pkg::*;
(
  // Clock and watched bus
  input  wire logic mclk,
  output cpu_watch_t cpu
);
  initial cpu = '0;
  // One access then one idle cycle; idle address is scrambled
  task automatic step(input logic [15:0] a, input logic x, input logic f);
    cpu <= '{a, a[7:0], 1'b1, x, f};
    @(posedge mclk);
    cpu <= '{~a, 8'h00, 1'b0, 1'b0, 1'b0};
    @(posedge mclk);
  endtask : step
endmodule : cpu_bus_model

// ---- debug_trigger_and_trace_status_bench.sv ----
`timescale 1ns/100ps
module debug_trigger_and_trace_status_bench;
  import debug_trigger_pkg::*;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        break_req, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  cpu_watch_t  cpu;
  trace_out_t  trace;
  int          miscompares, comparisons, brk, stores;
  logic [15:0] last_word;
  debug_trigger_and_trace_status dut (.mclk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu, .trace,
    .break_req, .irq);
  cpu_bus_model cm (.mclk, .cpu);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (break_req === 1'b1) brk <= brk + 1;
  // Count trace stores and keep the last word handed out
  always @(posedge mclk) begin
    if (trace.store === 1'b1) begin
      stores    <= stores + 1;
      last_word <= trace.word;
    end
  end
  task test_done;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 20);
    {err, rd} = {pslverr, prdata};
    if (n == 20) miscompares++;
    {psel, penable} <= 2'b00;
    @(posedge mclk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(e, rd);
  endtask : rc
  task t_reset;
    rc(OFF_TRIG_CFG, 32'h0);
    rc(OFF_STATUS, 32'h0);
    wr(OFF_TRIG_CFG, 32'hFF);
    rc(OFF_TRIG_CFG, 32'hCF);
    wr(OFF_STATUS, 32'hFF);
    rc(OFF_STATUS, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk(32'h1, {31'h0, err});
  endtask : t_reset
  task t_end_trace;
    wr(OFF_CMP_A, 32'h1234);
    wr(OFF_TRIG_CFG, 32'h0);
    wr(OFF_CONTROL, 32'hD0);
    wr(OFF_TRIG_CFG, 32'h1);
    rc(OFF_TRIG_CFG, 32'h0);
    rc(OFF_STATUS, 32'h20);
    for (int i = 0; i < 3; i++) cm.step(16'h0100 + 16'(i), 1'b1, 1'b1);
    cm.step(16'h1234, 1'b0, 1'b0);
    rc(OFF_STATUS, 32'h83);
    chk(32'h1, brk);
    chk(32'h3, stores);
    chk(32'h0102, {16'h0, last_word});
    chk(32'h0, {31'h0, irq});
    wr(OFF_IRQ_MASK, 32'h3);
    @(posedge mclk);
    chk(32'h1, {31'h0, irq});
    wr(OFF_IRQ_STAT, 32'h3);
    @(posedge mclk);
    chk(32'h0, {31'h0, irq});
  endtask : t_end_trace
  task t_qualify;
    wr(OFF_TRIG_CFG, 32'h80);
    wr(OFF_CONTROL, 32'hD0);
    cm.step(16'h1234, 1'b0, 1'b0);
    rc(OFF_STATUS, 32'h20);
    cm.step(16'h1234, 1'b1, 1'b0);
    rc(OFF_STATUS, 32'h80);
    chk(32'h2, brk);
  endtask : t_qualify
  task t_begin_trace;
    wr(OFF_CMP_B, 32'h0050);
    wr(OFF_TRIG_CFG, 32'h41);
    wr(OFF_CONTROL, 32'hD0);
    cm.step(16'h0050, 1'b1, 1'b0);
    rc(OFF_STATUS, 32'h60);
    for (int i = 0; i < 8; i++) cm.step(16'h0200 + 16'(i), 1'b1, 1'b1);
    rc(OFF_STATUS, 32'h48);
    chk(32'h3, brk);
    chk(32'd11, stores);
    chk(32'h0207, {16'h0, last_word});
  endtask : t_begin_trace
  task t_event;
    wr(OFF_TRIG_CFG, 32'h03);
    wr(OFF_CONTROL, 32'hD0);
    for (int i = 0; i < 8; i++) cm.step(16'h0050, 1'b1, 1'b0);
    rc(OFF_STATUS, 32'h48);
    chk(32'd19, stores);
    chk(32'h0050, {16'h0, last_word});
    chk(32'h4, brk);
    wr(OFF_CMP_A, 32'h0040);
    wr(OFF_TRIG_CFG, 32'h07);
    wr(OFF_CONTROL, 32'hD0);
    rc(OFF_STATUS, 32'h20);
    cm.step(16'h0045, 1'b1, 1'b0);
    rc(OFF_STATUS, 32'h00);
    chk(32'h5, brk);
  endtask : t_event
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_end_trace;
    t_qualify;
    t_begin_trace;
    t_event;
    test_done;
  end
  initial begin
    #50000;
    miscompares++;
    test_done;
  end
endmodule : debug_trigger_and_trace_status_bench
